//--- src/bcc_pkg.sv
// Shared constants and types for the bus command controller
package bcc_pkg;
    // Clock figures
    localparam int CLK_PERIOD_NS = 40;
    // Least grant-to-command delay in ns, rounded up to cycles
    localparam int GRANT_DELAY_NS = 100;
    localparam int GRANT_DELAY_CYC =
        (GRANT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GRANT_CNT_W = 4;

    // Status codes, bit 2 is status_line_2
    localparam logic [2:0] ST_IRQ_ACK  = 3'h0;
    localparam logic [2:0] ST_IO_RD    = 3'h1;
    localparam logic [2:0] ST_IO_WR    = 3'h2;
    localparam logic [2:0] ST_HALT     = 3'h3;
    localparam logic [2:0] ST_CODE     = 3'h4;
    localparam logic [2:0] ST_MEM_RD   = 3'h5;
    localparam logic [2:0] ST_MEM_WR   = 3'h6;
    localparam logic [2:0] ST_PASSIVE  = 3'h7;

    // Cycle sequencer states
    typedef enum logic [3:0] {
        BCC_IDLE  = 4'h1,
        BCC_ADDR  = 4'h2,
        BCC_CMD   = 4'h4,
        BCC_HALT  = 4'h8
    } bcc_state_e;
endpackage

//--- src/bcc_if.sv
// Link between processor-side logic and the bus command controller
`timescale 1ns/1ps
interface bcc_if;
    logic       status_line_0;
    logic       status_line_1;
    logic       status_line_2;
    logic       bus_mode_strap;
    logic       bus_grant_enable_n;
    logic       command_qualifier;
    logic       mem_read_strobe_n;
    logic       mem_write_strobe_n;
    logic       early_mem_write_strobe_n;
    logic       io_read_strobe_n;
    logic       io_write_strobe_n;
    logic       early_io_write_strobe_n;
    logic       irq_ack_strobe_n;
    logic       addr_latch_strobe;
    logic       xcvr_enable;
    logic       xcvr_direction;
    logic       cascade_or_periph_enable;

    modport device (
        input  status_line_0, status_line_1, status_line_2,
        input  bus_mode_strap, bus_grant_enable_n, command_qualifier,
        output mem_read_strobe_n, mem_write_strobe_n,
        output early_mem_write_strobe_n, io_read_strobe_n,
        output io_write_strobe_n, early_io_write_strobe_n,
        output irq_ack_strobe_n, addr_latch_strobe, xcvr_enable,
        output xcvr_direction, cascade_or_periph_enable
    );
    modport host (
        output status_line_0, status_line_1, status_line_2,
        output bus_mode_strap, bus_grant_enable_n, command_qualifier,
        input  mem_read_strobe_n, mem_write_strobe_n,
        input  early_mem_write_strobe_n, io_read_strobe_n,
        input  io_write_strobe_n, early_io_write_strobe_n,
        input  irq_ack_strobe_n, addr_latch_strobe, xcvr_enable,
        input  xcvr_direction, cascade_or_periph_enable
    );
endinterface

//--- src/bcc_device.sv
// Bus command controller: status decode, command and control outputs
// Behaviour
// - Decode status codes into commands
// - Wait grant delay after grant goes low
// - System mode: all commands await grant
// - I/O mode: I/O strobes ignore grant
// - Early writes use read timing
// - Interrupt acknowledge timed like I/O read
// - Drive transceiver enable and direction
// - Direction high on writes, low reads
// - I/O mode: shared pin is peripheral enable
// - System mode: cascade enable on acknowledges
// - Outside logic masks first cascade enable
// - Cascade enable precedes second acknowledge
// - Slave controller drives vector second cycle
// - Single controller: cascade enable unused
// - Address strobe pulses every machine cycle
// - Address strobe latches status for halt
// - Address strobe starts after status active
// - Disabled commands driven inactive, not floated
// - Qualifier low as the address strobe starts forces commands, transceiver and peripheral enables inactive
// - Qualifier settles before status goes active
`timescale 1ns/1ps
module bcc_device
    import bcc_pkg::*;
#(
    parameter int GRANT_CYCLES = GRANT_DELAY_CYC
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Link to processor side
    bcc_if.device     bus
);
    bcc_state_e               state;
    bcc_state_e               next_state;
    logic [1:0][2:0]          status_sync;
    logic [2:0]               status_now;
    logic [2:0]               status_latch;
    logic [1:0]               mode_sync;
    logic [1:0]               grant_sync;
    logic [1:0]               qual_sync;
    logic [GRANT_CNT_W-1:0]   grant_count;
    logic                     granted;
    logic                     qual_taken;
    logic                     io_mode;
    logic                     run;
    logic                     en_mem;
    logic                     en_io;

    // Command class of a status code
    function automatic logic is_write(input logic [2:0] code);
        return (code == ST_IO_WR) || (code == ST_MEM_WR);
    endfunction
    function automatic logic is_io(input logic [2:0] code);
        return (code == ST_IRQ_ACK) || (code == ST_IO_RD) ||
               (code == ST_IO_WR);
    endfunction
    function automatic logic is_cmd(input logic [2:0] code);
        return (code != ST_HALT) && (code != ST_PASSIVE);
    endfunction

    // Pins come from outside the clock domain: two flops each
    always_ff @(posedge clock) begin
        if (reset) begin
            status_sync <= '1;
            mode_sync   <= 2'h0;
            grant_sync  <= 2'h3;
            qual_sync   <= 2'h0;
        end else begin
            status_sync[0] <= {bus.status_line_2, bus.status_line_1,
                               bus.status_line_0};
            status_sync[1] <= status_sync[0];
            mode_sync      <= {mode_sync[0], bus.bus_mode_strap};
            grant_sync     <= {grant_sync[0], bus.bus_grant_enable_n};
            qual_sync      <= {qual_sync[0], bus.command_qualifier};
        end
    end
    assign status_now = status_sync[1];
    assign io_mode    = mode_sync[1];

    // Grant delay counter; grant drop ends grant-gated commands at once
    always_ff @(posedge clock) begin
        if (reset || grant_sync[1]) begin
            grant_count <= '0;
        end else if (grant_count != GRANT_CNT_W'(GRANT_CYCLES)) begin
            grant_count <= grant_count + GRANT_CNT_W'(1);
        end
    end
    assign granted = !grant_sync[1] &&
                     (grant_count == GRANT_CNT_W'(GRANT_CYCLES));

    // Cycle sequencer: idle, address strobe, command, halt
    always_comb begin
        next_state = state;
        unique case (state)
            BCC_IDLE: begin
                if (status_now != ST_PASSIVE) begin
                    next_state = BCC_ADDR;
                end
            end
            BCC_ADDR: begin
                next_state = is_cmd(status_latch) ? BCC_CMD
                                                  : BCC_HALT;
            end
            BCC_CMD, BCC_HALT: begin
                if (status_now == ST_PASSIVE) begin
                    next_state = BCC_IDLE;
                end
            end
            default: next_state = BCC_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= BCC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Status and qualifier caught as the address strobe begins
    always_ff @(posedge clock) begin
        if (reset) begin
            status_latch <= ST_PASSIVE;
            qual_taken   <= 1'b0;
        end else if (state == BCC_IDLE && next_state == BCC_ADDR) begin
            status_latch <= status_now;
            qual_taken   <= qual_sync[1];
        end
    end

    // Command gating; a qualifier change mid-cycle is not seen
    assign run    = (next_state == BCC_CMD) && qual_taken;
    assign en_mem = run && granted;
    assign en_io  = run && (io_mode || granted);

    // Address strobe: one pulse as the address phase starts
    always_ff @(posedge clock) begin
        if (reset) begin
            bus.addr_latch_strobe <= 1'b0;
        end else begin
            bus.addr_latch_strobe <= (next_state == BCC_ADDR);
        end
    end

    // I/O side strobes; idle level is driven, never floated
    always_ff @(posedge clock) begin
        if (reset) begin
            bus.io_read_strobe_n        <= 1'b1;
            bus.io_write_strobe_n       <= 1'b1;
            bus.early_io_write_strobe_n <= 1'b1;
            bus.irq_ack_strobe_n        <= 1'b1;
        end else begin
            bus.io_read_strobe_n <=
                !(en_io && status_latch == ST_IO_RD);
            // Second acknowledge alone can gate a lone controller's vector
            bus.irq_ack_strobe_n <=
                !(en_io && status_latch == ST_IRQ_ACK);
            bus.early_io_write_strobe_n <=
                !(en_io && status_latch == ST_IO_WR);
            // Late write waits one cycle so data can settle
            bus.io_write_strobe_n <=
                !(en_io && status_latch == ST_IO_WR && state == BCC_CMD);
        end
    end

    // Memory side strobes; a grant drop releases them at once
    always_ff @(posedge clock) begin
        if (reset) begin
            bus.mem_read_strobe_n        <= 1'b1;
            bus.mem_write_strobe_n       <= 1'b1;
            bus.early_mem_write_strobe_n <= 1'b1;
        end else begin
            bus.mem_read_strobe_n <= !(en_mem &&
                (status_latch == ST_CODE || status_latch == ST_MEM_RD));
            bus.early_mem_write_strobe_n <=
                !(en_mem && status_latch == ST_MEM_WR);
            // Late write waits one cycle so data can settle
            bus.mem_write_strobe_n <= !(en_mem &&
                status_latch == ST_MEM_WR && state == BCC_CMD);
        end
    end

    // Transceiver controls; in I/O mode the shared pin serves I/O codes
    always_ff @(posedge clock) begin
        if (reset) begin
            bus.xcvr_enable    <= 1'b0;
            bus.xcvr_direction <= 1'b0;
        end else begin
            bus.xcvr_enable    <= run && granted &&
                !(io_mode && is_io(status_latch));
            bus.xcvr_direction <= (next_state == BCC_CMD) &&
                                  is_write(status_latch);
        end
    end

    // Shared pin: peripheral enable in I/O mode, else cascade enable
    always_ff @(posedge clock) begin
        if (reset) begin
            bus.cascade_or_periph_enable <= 1'b0;
        end else if (io_mode) begin
            bus.cascade_or_periph_enable <=
                run && is_io(status_latch);
        end else begin
            // Raised with address strobe so cascade gets latched
            bus.cascade_or_periph_enable <=
                (next_state == BCC_ADDR) &&
                (status_now == ST_IRQ_ACK);
        end
    end
endmodule

//--- src/bcc_host.sv
// Processor-side driver: status codes, grant and qualifier
`timescale 1ns/1ps
module bcc_host
    import bcc_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // User side
    input  wire logic       cycle_start,
    input  wire logic [2:0] cycle_code,
    input  wire logic       cycle_end,
    input  wire logic       io_bus_mode,
    input  wire logic       grant_n,
    input  wire logic       qualifier,
    output logic            cycle_busy,
    output logic            cascade_masked,
    // Link to controller
    bcc_if.host             bus
);
    logic [2:0] code;
    logic       ack_second;

    // Status held until the cycle ends; qualifier set first
    always_ff @(posedge clock) begin
        if (reset) begin
            code       <= ST_PASSIVE;
            cycle_busy <= 1'b0;
        end else if (cycle_end) begin
            code       <= ST_PASSIVE;
            cycle_busy <= 1'b0;
        end else if (cycle_start && !cycle_busy) begin
            code       <= cycle_code;
            cycle_busy <= 1'b1;
        end
    end

    // Track acknowledge pairs; first one carries no transfer
    always_ff @(posedge clock) begin
        if (reset) begin
            ack_second <= 1'b0;
        end else if (cycle_end && code == ST_IRQ_ACK) begin
            ack_second <= !ack_second;
        end
    end
    // Mask cascade enable on first acknowledge
    assign cascade_masked = bus.cascade_or_periph_enable &&
                            (ack_second || io_bus_mode);

    // Pin drive
    assign bus.status_line_0      = code[0];
    assign bus.status_line_1      = code[1];
    assign bus.status_line_2      = code[2];
    assign bus.bus_mode_strap     = io_bus_mode;
    assign bus.bus_grant_enable_n = grant_n;
    assign bus.command_qualifier  = qualifier;
endmodule

//--- tb/bcc_asserts.sv
// Concurrent checks on the link between the two controller ends
`timescale 1ns/1ps
module bcc_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Processor side
    input wire logic status_line_0,
    input wire logic status_line_1,
    input wire logic status_line_2,
    input wire logic bus_mode_strap,
    input wire logic bus_grant_enable_n,
    input wire logic command_qualifier,
    // Controller side
    input wire logic mem_read_strobe_n,
    input wire logic mem_write_strobe_n,
    input wire logic early_mem_write_strobe_n,
    input wire logic io_read_strobe_n,
    input wire logic io_write_strobe_n,
    input wire logic early_io_write_strobe_n,
    input wire logic irq_ack_strobe_n,
    input wire logic addr_latch_strobe,
    input wire logic xcvr_enable,
    input wire logic xcvr_direction,
    input wire logic cascade_or_periph_enable
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    // Pin code and a summary of all command strobes being idle
    wire [2:0] code = {status_line_2, status_line_1, status_line_0};
    wire       idle = &{mem_read_strobe_n, mem_write_strobe_n,
        early_mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n,
        early_io_write_strobe_n, irq_ack_strobe_n};
    // Strobes lag the pins by sync plus register, so look 3 back
    property p_mrd;
        !mem_read_strobe_n |-> $past(code, 3) inside {3'h4, 3'h5};
    endproperty
    a_mrd: assert property (p_mrd)
        else $error("memory read strobe without read code");
    property p_ack;
        !irq_ack_strobe_n |-> $past(code, 3) == 3'h0 && io_read_strobe_n;
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge strobe without acknowledge code");
    property p_early;
        (!mem_write_strobe_n |-> !early_mem_write_strobe_n) and
        (!io_write_strobe_n |-> !early_io_write_strobe_n);
    endproperty
    a_early: assert property (p_early)
        else $error("late write strobe outside early write");
    property p_dir;
        (!mem_write_strobe_n || !io_write_strobe_n |-> xcvr_direction) and
        (!mem_read_strobe_n || !io_read_strobe_n |-> !xcvr_direction);
    endproperty
    a_dir: assert property (p_dir)
        else $error("transceiver direction wrong");
    property p_grant_delay;
        !bus_mode_strap && $fell(mem_read_strobe_n) |->
            !$past(bus_grant_enable_n, 1) && !$past(bus_grant_enable_n, 2)
            && !$past(bus_grant_enable_n, 3);
    endproperty
    a_grant_delay: assert property (p_grant_delay)
        else $error("memory read before grant delay");
    property p_grant_lost;
        (bus_grant_enable_n && !bus_mode_strap)[*4] |-> mem_read_strobe_n
            && mem_write_strobe_n && io_read_strobe_n && io_write_strobe_n;
    endproperty
    a_grant_lost: assert property (p_grant_lost)
        else $error("command strobe without grant");
    property p_latch;
        $past(code) == 3'h7 && code != 3'h7 |->
            ##[2:4] (addr_latch_strobe ##1 !addr_latch_strobe);
    endproperty
    a_latch: assert property (p_latch)
        else $error("latch strobe missing or too long");
    property p_quiet;
        (code == 3'h7 || code == 3'h3)[*6] |-> idle && !xcvr_enable;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("strobe active while halted or passive");
    property p_qual;
        (!command_qualifier && code == 3'h7)[*4] ##1 (!command_qualifier)[*4]
            |-> idle && !xcvr_enable;
    endproperty
    a_qual: assert property (p_qual)
        else $error("strobe active while commands disabled");
    property p_cascade;
        cascade_or_periph_enable && !bus_mode_strap |-> addr_latch_strobe
            && code == 3'h0;
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("cascade enable outside acknowledge address phase");
endmodule

//--- tb/testbench.sv
// Self-checking bench for the controller and processor-side ends
`timescale 1ns/1ps
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
    err_total++; $display("BAD %0t got %0h exp %0h", $time, got, exp); \
    end end
module testbench;
    import bcc_pkg::*;
    // Clock, reset and host user side
    logic       clock;
    logic       reset;
    logic       cycle_start;
    logic [2:0] cycle_code;
    logic       cycle_end;
    logic       io_bus_mode;
    logic       grant_n;
    logic       qualifier;
    logic       cycle_busy;
    logic       cascade_masked;
    // Scoreboard
    int         err_total;
    int         cmp_count;
    logic [6:0] seen;
    logic [3:0] ctl_seen;
    logic       gather;
    int         latches;
    int         acks;

    bcc_if bus ();
    bcc_device #(.GRANT_CYCLES(GRANT_DELAY_CYC)) i_bcc_device (
        .clock(clock), .reset(reset), .bus(bus));
    bcc_host i_bcc_host (.clock(clock), .reset(reset),
        .cycle_start(cycle_start), .cycle_code(cycle_code),
        .cycle_end(cycle_end), .io_bus_mode(io_bus_mode),
        .grant_n(grant_n), .qualifier(qualifier),
        .cycle_busy(cycle_busy), .cascade_masked(cascade_masked),
        .bus(bus));
    bcc_asserts i_bcc_asserts (.clock(clock), .reset(reset),
        .status_line_0(bus.status_line_0), .status_line_1(bus.status_line_1),
        .status_line_2(bus.status_line_2),
        .bus_mode_strap(bus.bus_mode_strap),
        .bus_grant_enable_n(bus.bus_grant_enable_n),
        .command_qualifier(bus.command_qualifier),
        .mem_read_strobe_n(bus.mem_read_strobe_n),
        .mem_write_strobe_n(bus.mem_write_strobe_n),
        .early_mem_write_strobe_n(bus.early_mem_write_strobe_n),
        .io_read_strobe_n(bus.io_read_strobe_n),
        .io_write_strobe_n(bus.io_write_strobe_n),
        .early_io_write_strobe_n(bus.early_io_write_strobe_n),
        .irq_ack_strobe_n(bus.irq_ack_strobe_n),
        .addr_latch_strobe(bus.addr_latch_strobe),
        .xcvr_enable(bus.xcvr_enable), .xcvr_direction(bus.xcvr_direction),
        .cascade_or_periph_enable(bus.cascade_or_periph_enable));

    // 25 MHz clock
    initial clock = 1'b0;
    always #20 clock = ~clock;

    // Gather strobes and controls seen active while a cycle runs
    always @(posedge clock) begin
        if (!gather) begin
            seen     <= 7'h00;
            ctl_seen <= 4'h0;
            latches  <= 0;
        end else begin
            seen <= seen | ~{bus.mem_read_strobe_n, bus.mem_write_strobe_n,
                bus.early_mem_write_strobe_n, bus.io_read_strobe_n,
                bus.io_write_strobe_n, bus.early_io_write_strobe_n,
                bus.irq_ack_strobe_n};
            ctl_seen <= ctl_seen | {bus.xcvr_enable, bus.xcvr_direction,
                bus.cascade_or_periph_enable, cascade_masked};
            latches <= latches + int'(bus.addr_latch_strobe);
        end
    end

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Strobes expected for a code; memory always needs grant, I/O only in system mode
    function automatic logic [6:0] exp_mask(input int c, input int m,
                                            input int g, input int q);
        logic [6:0] e;
        case (c)
            0: e = 7'h01;
            1: e = 7'h08;
            2: e = 7'h06;
            4, 5: e = 7'h40;
            6: e = 7'h30;
            default: e = 7'h00;
        endcase
        if (q == 0) e = 7'h00;
        else if (g == 1) e = (m == 1) ? (e & 7'h0F) : 7'h00;
        return e;
    endfunction

    // Controls expected: enable, direction, shared pin, masked pin
    function automatic logic [3:0] exp_ctl(input int c, input int m,
                                           input int g, input int q,
                                           input int odd);
        logic       cmd;
        logic       io;
        logic [3:0] e;
        cmd = (c != 3) && (c != 7);
        io = (c < 3);
        e[3] = cmd && q == 1 && g == 0 && (m == 0 || !io);
        e[2] = (c == 2) || (c == 6);
        e[1] = (m == 1) ? (io && q == 1) : (c == 0);
        e[0] = e[1] && (m == 1 || odd == 1);
        return e;
    endfunction

    // One bus cycle of a code, then back to passive; entered just after edge
    task automatic run_cycle(input logic [2:0] code, input logic [6:0] exp,
                             input logic [3:0] exp_c);
        int n;
        gather = 1'b1;
        cycle_code = code;
        cycle_start = 1'b1;
        @(posedge clock) #1;
        cycle_start = 1'b0;
        repeat (12) @(posedge clock);
        #1 cycle_end = 1'b1;
        @(posedge clock) #1;
        cycle_end = 1'b0;
        n = 0;
        while (cycle_busy !== 1'b0 && n < 20) begin
            @(posedge clock) #1;
            n++;
        end
        if (n == 20) begin
            err_total++;
            wrap_up();
        end else begin
            // Passive takes three edges to clear the strobes
            repeat (4) @(posedge clock);
            #1 `CHECK(seen, exp)
            `CHECK(latches, (code == 3'h7) ? 0 : 1)
            `CHECK(ctl_seen, exp_c)
            gather = 1'b0;
        end
    endtask

    initial begin
        reset = 1'b1;
        cycle_start = 1'b0;
        cycle_code = 3'h7;
        cycle_end = 1'b0;
        io_bus_mode = 1'b0;
        grant_n = 1'b1;
        qualifier = 1'b1;
        err_total = 0;
        cmp_count = 0;
        gather = 1'b0;
        acks = 0;
        repeat (6) @(posedge clock);
        #1 reset = 1'b0;
        @(posedge clock) #1;
        // Every code under every mode, grant and qualifier setting
        for (int m = 0; m < 2; m++)
            for (int g = 0; g < 2; g++)
                for (int q = 0; q < 2; q++)
                    for (int c = 0; c < 8; c++) begin
                        io_bus_mode = m[0];
                        grant_n = g[0];
                        qualifier = q[0];
                        repeat (6) @(posedge clock);
                        #1 run_cycle(c[2:0], exp_mask(c, m, g, q),
                                     exp_ctl(c, m, g, q, acks % 2));
                        if (c == 0) acks++;
                    end
        // Grant lands mid-read: the strobe must wait out the delay
        io_bus_mode = 1'b0;
        grant_n = 1'b1;
        repeat (6) @(posedge clock);
        #1 fork
            run_cycle(3'h5, 7'h40, exp_ctl(5, 0, 0, 1, 0));
            begin
                repeat (5) @(posedge clock);
                #1 grant_n = 1'b0;
                repeat (GRANT_DELAY_CYC) begin
                    @(posedge clock) #1;
                    `CHECK(bus.mem_read_strobe_n, 1'b1)
                end
            end
        join
        wrap_up();
    end
endmodule
